// file: hdl/hold_timer.sv
`timescale 1ns/100ps
// down-counter that pulses done after a loaded number of cycles
module hold_timer
  import xcvr_ctrl_pkg::*;
#(
  parameter int W = CNT_W
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  // status
  output logic              done
);
  logic [W-1:0] cnt_q, cnt_d;
  logic         run_q, run_d, done_d;

  always_comb begin
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (load) begin
      cnt_d = count;
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q <= W'(1)) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      done  <= done_d;
    end
  end
endmodule // hold_timer

// file: hdl/xcvr_ctrl.sv
`timescale 1ns/100ps
// controller driving the transceiver mode pins and inhibit-mask sequence
module xcvr_ctrl
  import xcvr_ctrl_pkg::*;
#(
  parameter int HOLD_CYCLES   = MASK_HOLD_CYCLES,
  parameter int SETTLE_CYCLES = MODE_SETTLE_CYCLES
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // user command port
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd_code,
  output logic            cmd_ready,
  output logic            cmd_done,
  output logic [1:0]      cmd_err,
  output logic            mask_active,
  output logic            wake_seen,
  // user data path
  input  wire logic       user_tx,
  output logic            user_rx,
  // device pins
  output logic            tx_data_out,
  input  wire logic       rx_data_in,
  input  wire logic       status_flag_out_n,
  output logic            mode_sel_a,
  output logic            mode_sel_b_n,
  output logic            inhibit_disable_in
);
  typedef enum logic [2:0] {
    ST_IDLE,   // waiting for a command
    ST_SETTLE, // mode pins moved, device following
    ST_CHECK,  // mask command: flag must be clear first
    ST_DRIVE,  // mask pin held past the filter time
    ST_ACK     // waiting for the flag to drop
  } state_t;

  // command sequencer
  state_t     st_q, st_d;
  logic [1:0] mode_q, mode_d;
  logic       mask_q, mask_d, mask_pin_q, mask_pin_d;
  logic       mask_tgt_q, mask_tgt_d;
  logic [2:0] req_q, req_d;
  logic       ready_q, ready_d, done_q, done_d;
  logic [1:0] err_q, err_d;
  logic       wake_q, wake_d, tx_q, rx_q;
  // one timer serves the settle, hold and ack windows in turn
  logic       tmr_load;
  logic [CNT_W-1:0] tmr_count;
  logic       tmr_done;

  // reloaded at every state change that opens a window
  hold_timer #(.W(CNT_W)) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .count    (tmr_count),
    .done     (tmr_done)
  );

  always_comb begin
    st_d       = st_q;
    mode_d     = mode_q;
    mask_d     = mask_q;
    mask_pin_d = mask_pin_q;
    mask_tgt_d = mask_tgt_q;
    req_d      = req_q;
    ready_d    = ready_q;
    done_d     = 1'b0;
    err_d      = err_q;
    wake_d     = wake_q;
    tmr_load   = 1'b0;
    tmr_count  = CNT_W'(SETTLE_CYCLES);
    // receive low outside normal marks power-on or wake; in normal
    // it is only the echo of transmit, so the flag clears there
    if (mode_q == MODE_NORMAL_CODE)
      wake_d = 1'b0;
    else if (rx_data_in == 1'b0)
      wake_d = 1'b1;
    unique case (st_q)
      ST_IDLE: begin
        // commands offered while busy are ignored, never queued
        if (cmd_valid && ready_q) begin
          ready_d = 1'b0;
          req_d   = cmd_code;
          err_d   = ERR_NONE;
          tmr_load = 1'b1;
          unique case (cmd_code)
            REQ_NORMAL:  mode_d = MODE_NORMAL_CODE;
            REQ_STANDBY: mode_d = MODE_STANDBY_CODE;
            REQ_SLEEP:   mode_d = MODE_SLEEP_CODE;
            default:     mode_d = MODE_SILENT_CODE;
          endcase
          // no guard against inhibit feeding our own supply: the system
          // must not issue mask commands in that wiring
          mask_tgt_d = (cmd_code == REQ_MASK_ON);
          st_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        // mode commands end here; mask commands go on to the flag check
        if (tmr_done) begin
          if (req_q == REQ_MASK_ON || req_q == REQ_MASK_OFF)
            st_d = ST_CHECK;
          else begin
            st_d    = ST_IDLE;
            ready_d = 1'b1;
            done_d  = 1'b1;
          end
        end
      end
      ST_CHECK: begin
        // a low flag here would hide the acknowledgement
        if (!status_flag_out_n) begin
          err_d   = ERR_FAULT;
          st_d    = ST_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end else begin
          mask_pin_d = mask_tgt_q;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(HOLD_CYCLES);
          st_d       = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        // pin held past the filter time so the device latches it
        if (tmr_done) begin
          // ack window reuses the settle count
          tmr_load = 1'b1;
          st_d     = ST_ACK;
        end
      end
      ST_ACK: begin
        if (!status_flag_out_n) begin
          mask_d  = mask_tgt_q;
          st_d    = ST_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end else if (tmr_done) begin
          // pin left driven: our mask copy may now differ from the device
          err_d   = ERR_NO_ACK;
          st_d    = ST_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= ST_IDLE;
      mode_q     <= MODE_STANDBY_CODE;
      // our copy restarts cleared; the device keeps its own latch
      mask_q     <= 1'b0;
      mask_pin_q <= 1'b0;
      mask_tgt_q <= 1'b0;
      req_q      <= REQ_NORMAL;
      ready_q    <= 1'b1;
      done_q     <= 1'b0;
      err_q      <= ERR_NONE;
      wake_q     <= 1'b0;
      tx_q       <= 1'b1;
      rx_q       <= 1'b1;
    end else begin
      st_q       <= st_d;
      mode_q     <= mode_d;
      mask_q     <= mask_d;
      mask_pin_q <= mask_pin_d;
      mask_tgt_q <= mask_tgt_d;
      req_q      <= req_d;
      ready_q    <= ready_d;
      done_q     <= done_d;
      err_q      <= err_d;
      wake_q     <= wake_d;
      // only drive dominant in normal mode
      tx_q <= (mode_q == MODE_NORMAL_CODE) ? user_tx : 1'b1;
      rx_q <= rx_data_in;
    end
  end

  // all pins and status outputs are register bits
  assign tx_data_out        = tx_q;
  assign user_rx            = rx_q;
  assign mode_sel_a         = mode_q[1];
  assign mode_sel_b_n       = mode_q[0];
  assign inhibit_disable_in = mask_pin_q;
  assign cmd_ready          = ready_q;
  assign cmd_done           = done_q;
  assign cmd_err            = err_q;
  assign mask_active        = mask_q;
  assign wake_seen          = wake_q;
endmodule // xcvr_ctrl

// file: hdl/xcvr_ctrl_pkg.sv
// constants for the transceiver mode and inhibit-mask controller
package xcvr_ctrl_pkg;
  localparam int CLK_FREQ_HZ          = 40_000_000;
  // mask filter time of the device; the controller holds mask longer than this
  localparam int MASK_FILTER_TIME_US  = 100;
  localparam int MASK_HOLD_MARGIN_US  = 20;
  localparam int MASK_HOLD_CYCLES     =
    ((MASK_FILTER_TIME_US + MASK_HOLD_MARGIN_US) * (CLK_FREQ_HZ / 1_000_000));
  // settle time after a mode change before reading the status flag
  localparam int MODE_SETTLE_TIME_US  = 50;
  localparam int MODE_SETTLE_CYCLES   =
    MODE_SETTLE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int CNT_W                = 16;
  // mode-select pin encoding {enable, standby_n}; integrator may override
  localparam logic [1:0] MODE_NORMAL_CODE  = 2'h3;
  localparam logic [1:0] MODE_SILENT_CODE  = 2'h2;
  localparam logic [1:0] MODE_STANDBY_CODE = 2'h0;
  localparam logic [1:0] MODE_SLEEP_CODE   = 2'h1;
  // user mode and mask requests
  localparam logic [2:0] REQ_NORMAL  = 3'h0;
  localparam logic [2:0] REQ_SILENT  = 3'h1;
  localparam logic [2:0] REQ_STANDBY = 3'h2;
  localparam logic [2:0] REQ_SLEEP   = 3'h3;
  localparam logic [2:0] REQ_MASK_ON = 3'h4;
  localparam logic [2:0] REQ_MASK_OFF= 3'h5;
  localparam logic [1:0] ERR_NONE    = 2'h0;
  localparam logic [1:0] ERR_BUSY    = 2'h1;
  localparam logic [1:0] ERR_FAULT   = 2'h2;
  localparam logic [1:0] ERR_NO_ACK  = 2'h3;
endpackage

// file: testbench/xcvr_ctrl_chk.sv
// port assertions for the transceiver controller
`timescale 1ns/100ps
module xcvr_ctrl_chk
  import xcvr_ctrl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // command port
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic mask_active,
  // data path
  input wire logic user_tx,
  input wire logic user_rx,
  input wire logic tx_data_out,
  input wire logic rx_data_in,
  // mode and mask pins
  input wire logic mode_sel_a,
  input wire logic mode_sel_b_n,
  input wire logic inhibit_disable_in,
  input wire logic status_flag_out_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire       nrm  = mode_sel_a & mode_sel_b_n;
  wire [1:0] mode = {mode_sel_a, mode_sel_b_n};
  wire [2:0] pins = {mode_sel_a, mode_sel_b_n, inhibit_disable_in};
  a_tx_recess: assert property (
    !nrm && !$past(nrm) |-> tx_data_out) else $error("tx not recessive");
  a_tx_pass: assert property (
    nrm && $past(nrm) |-> tx_data_out == $past(user_tx))
    else $error("tx path broken");
  a_rx_pass: assert property (
    $past(rst_n) |-> user_rx == $past(rx_data_in))
    else $error("rx path broken");
  a_mask_silent: assert property (
    $changed(inhibit_disable_in) |-> mode == MODE_SILENT_CODE)
    else $error("mask pin moved outside silent");
  a_flag_clear: assert property (
    $changed(inhibit_disable_in) |-> $past(status_flag_out_n))
    else $error("mask pin moved over a low flag");
  a_mode_take: assert property (
    $changed(mode) |-> $past(cmd_valid && cmd_ready))
    else $error("mode pins moved without command");
  a_idle_stable: assert property (
    cmd_ready && !cmd_valid |=> $stable(pins)) else $error("idle pins moved");
  a_take_busy: assert property (
    cmd_valid && cmd_ready |=> !cmd_ready [*5]) else $error("ready too soon");
  a_mask_done: assert property (
    $changed(mask_active) |-> cmd_done || $past(cmd_done))
    else $error("mask state moved without done");
  a_done_pulse: assert property (
    cmd_done |=> !cmd_done) else $error("done longer than one cycle");
  c_mask: cover property (cmd_done && mask_active);
  c_tx: cover property (nrm && !tx_data_out);
  c_pin: cover property ($changed(inhibit_disable_in));
endmodule // xcvr_ctrl_chk

bind xcvr_ctrl xcvr_ctrl_chk xcvr_ctrl_chk_inst (.*);

// file: testbench/xcvr_ctrl_test.sv
// directed test of the transceiver controller
`timescale 1ns/100ps
module xcvr_ctrl_test;
  import xcvr_ctrl_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       cmd_valid = 1'b0;
  logic [2:0] cmd_code = 3'h0;
  logic       user_tx = 1'b1;
  logic       wake = 1'b0;
  logic       fault = 1'b0;
  logic       mute = 1'b0;
  logic       cmd_ready, cmd_done, mask_active, wake_seen, user_rx;
  logic       tx_data_out, rx_data_in, status_flag_out_n, supply_inhibit_out;
  logic       mode_sel_a, mode_sel_b_n, inhibit_disable_in;
  logic [1:0] cmd_err;
  int         n_mismatch = 0;
  int         check_count = 0;
  xcvr_ctrl #(.HOLD_CYCLES(10), .SETTLE_CYCLES(5)) xcvr_ctrl_inst (.*);
  xcvr_model xcvr_model_inst (.*);
  initial forever #12.5 core_clk = ~core_clk;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkm(input logic [1:0] m);
    chk({1'b0, mode_sel_a, mode_sel_b_n}, {1'b0, m});
  endtask
  // request held until taken, then bounded wait for done
  task automatic run(input logic [2:0] code, input logic [1:0] err);
    int i;
    int j;
    cmd_code = code;
    cmd_valid = 1'b1;
    for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    for (j = 0; j < 200 && cmd_done !== 1'b1; j++) @(negedge core_clk);
    if (i == 200 || j == 200) begin
      n_mismatch++;
      $display("Error at %0t: command %h timed out", $time, code);
      end_sim();
    end else begin
      @(negedge core_clk);
      chk({1'b0, cmd_err}, {1'b0, err});
    end
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chkm(MODE_STANDBY_CODE);
    chk({2'b0, inhibit_disable_in}, 3'h0);
    chk({2'b0, wake_seen}, 3'h1);
    run(REQ_NORMAL, ERR_NONE);
    chkm(MODE_NORMAL_CODE);
    chk({2'b0, wake_seen}, 3'h0);
    user_tx = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({1'b0, tx_data_out, user_rx}, 3'h0);
    run(REQ_SILENT, ERR_NONE);
    chk({2'b0, tx_data_out}, 3'h1);
    user_tx = 1'b1;
    run(REQ_MASK_ON, ERR_NONE);
    chk({inhibit_disable_in, mask_active, supply_inhibit_out}, 3'h6);
    run(REQ_STANDBY, ERR_NONE);
    chk({inhibit_disable_in, mask_active, supply_inhibit_out}, 3'h6);
    fault = 1'b1;
    run(REQ_MASK_OFF, ERR_FAULT);
    fault = 1'b0;
    run(REQ_MASK_OFF, ERR_NONE);
    chk({inhibit_disable_in, mask_active, supply_inhibit_out}, 3'h1);
    run(REQ_STANDBY, ERR_NONE);
    mute = 1'b1;
    run(REQ_MASK_ON, ERR_NO_ACK);
    chk({1'b0, inhibit_disable_in, mask_active}, 3'h2);
    mute = 1'b0;
    run(REQ_NORMAL, ERR_NONE);
    run(REQ_STANDBY, ERR_NONE);
    wake = 1'b1;
    @(negedge core_clk);
    wake = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({1'b0, wake_seen, user_rx}, 3'h2);
    run(REQ_SLEEP, ERR_NONE);
    chkm(MODE_SLEEP_CODE);
    end_sim();
  end
endmodule // xcvr_ctrl_test

// file: testbench/xcvr_model.sv
// behavioural model of the transceiver logic pins
`timescale 1ns/100ps
module xcvr_model #(
  parameter int FILT = 6,
  // dominant timeout in cycles, shortened to keep the run short
  parameter int DTO  = 200
) (
  // controller side
  input  wire logic core_clk,
  input  wire logic tx_data_out,
  input  wire logic mode_sel_a,
  input  wire logic mode_sel_b_n,
  input  wire logic inhibit_disable_in,
  output logic      rx_data_in,
  output logic      status_flag_out_n,
  output logic      supply_inhibit_out,
  // scenario controls
  input  wire logic wake,
  input  wire logic fault,
  input  wire logic mute
);
  // not reset by the controller: mask survives its resets
  // besides a filtered low on the pin in silent, only a battery dip would clear the mask; the dip is not modelled
  logic mask_q = 1'b0;
  logic chg_q  = 1'b0;
  logic wk_q   = 1'b1;
  logic pwr_q  = 1'b1;
  int   n      = 0;
  int   d      = 0;
  wire  nrm    = mode_sel_a & mode_sel_b_n;
  wire  sil    = mode_sel_a & !mode_sel_b_n;
  wire  slp    = !mode_sel_a & mode_sel_b_n;
  wire  stb    = !mode_sel_a & !mode_sel_b_n;
  always @(posedge core_clk) begin
    n <= (sil && inhibit_disable_in != mask_q) ? n + 1 : 0;
    d <= (nrm && !tx_data_out) ? d + 1 : 0;
    if (n == FILT) begin
      mask_q <= inhibit_disable_in;
      chg_q  <= !mute;
    end
    if (!sil) chg_q <= 1'b0;
    if (wake) wk_q <= 1'b1;
    if (nrm) begin
      wk_q  <= 1'b0;
      pwr_q <= 1'b0;
    end
  end
  // active and passive recessive phases read the same on the logic pin
  assign rx_data_in = nrm ? (tx_data_out | (d > DTO))
                          : !wk_q;
  assign status_flag_out_n = slp ? 1'bz :
    !(chg_q | fault | (stb & wk_q) | (sil & pwr_q));
  assign supply_inhibit_out = (slp && !wk_q) ? 1'bz : !mask_q;
endmodule // xcvr_model
